/* File: core/lem_udr.sv */
// link error monitor counter and its threshold register, the
// interrupt condition flags it owns, and the user sense/enable register
// assumes a single-cycle control bus request synchronous to I_CLK and a
// one-cycle link error pulse from the receive path
// sense pins may change at any time; they pass two flops and then need four high samples in a row, so a
// glitch shorter than three clock periods never reaches a sense bit
// enable pins follow the register one clock after it is written
`timescale 1ns/1ps

module lem_udr #(
	parameter bit DUAL_PATH = 1'b1
) (
	input  wire logic                  I_CLK,
	input  wire logic                  I_RST_B,
	input  wire lem_udr_pkg::cb_req_t  I_CB_REQ,
	input  wire logic                  I_LINK_ERR,
	input  wire logic [2:0]            I_SENSE_PIN,
	output lem_udr_pkg::cb_rsp_t       O_CB_RSP,
	output logic [2:0]                 O_ENABLE_PIN,
	output logic [7:0]                 O_ICR
);

	// decoded accesses
	logic rd_en;
	logic wr_en;
	assign rd_en = I_CB_REQ.sel & ~I_CB_REQ.wr;
	assign wr_en = I_CB_REQ.sel & I_CB_REQ.wr;

	// sense pin synchronisers and qualification counters
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [2:0] sense_hit;
	logic [2:0] sense_hit_r;
	logic [2:0] sense_hit_nxt;
	logic [2:0] sync1_nxt;
	logic [2:0] sync2_nxt;

	// sync1_r feeds only sync2_r, never the qualification logic
	always_comb begin
		sync1_nxt = I_SENSE_PIN;
		sync2_nxt = sync1_r;
	end

	// two flops so a pin moving near the edge cannot upset the counters
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sense
			logic [3:0] hold_r;
			logic [3:0] hold_nxt;
			// count consecutive high cycles; a single low sample restarts
			always_comb begin
				hold_nxt = hold_r;
				if (!sync2_r[g])
					hold_nxt = 4'h0;
				else if (hold_r != lem_udr_pkg::SENSE_HOLD_CNT)
					hold_nxt = hold_r + 4'h1;
			end
			always_ff @(posedge I_CLK or negedge I_RST_B) begin
				if (!I_RST_B)
					hold_r <= 4'h0;
				else
					hold_r <= hold_nxt;
			end
			// qualified level; the third pin is inert on single-path parts
			assign sense_hit[g] = (hold_r == lem_udr_pkg::SENSE_HOLD_CNT)
				&& ((g != 2) || DUAL_PATH);
		end
	endgenerate

	// registered copy so the latch sees a clean one-flop path
	always_comb begin
		sense_hit_nxt = sense_hit;
	end

	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B)
			sense_hit_r <= 3'h0;
		else
			sense_hit_r <= sense_hit_nxt;
	end

	// decoded register selects, shared by the state groups below
	logic wr_thresh;
	logic wr_count;
	logic wr_user;
	logic wr_icr;
	logic wr_icr_cmp;
	logic rd_icr;

	assign wr_thresh  = wr_en && (I_CB_REQ.addr == lem_udr_pkg::ADDR_THRESH);
	assign wr_count   = wr_en && (I_CB_REQ.addr == lem_udr_pkg::ADDR_COUNT);
	assign wr_user    = wr_en && (I_CB_REQ.addr == lem_udr_pkg::ADDR_USER);
	assign wr_icr     = wr_en && (I_CB_REQ.addr == lem_udr_pkg::ADDR_ICR);
	assign wr_icr_cmp = wr_en && (I_CB_REQ.addr == lem_udr_pkg::ADDR_ICR_CMP);
	assign rd_icr     = rd_en && (I_CB_REQ.addr == lem_udr_pkg::ADDR_ICR);

	// link error counter and its threshold
	logic [7:0] thresh_r;
	logic [7:0] thresh_nxt;
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic       thresh_hit;

	// a count of 0 or 1 reloads the threshold on this error; 0 occurs after reset
	// and whenever the threshold is zero, since a load copies the threshold
	// a host load wins over a same-cycle error; the flag still sets then
	always_comb begin
		thresh_nxt = thresh_r;
		count_nxt  = count_r;
		thresh_hit = 1'b0;
		if (I_LINK_ERR) begin
			if (count_r <= 8'h01)
				thresh_hit = 1'b1;
			else
				count_nxt = count_r - 8'h01;
		end
		if (thresh_hit)
			count_nxt = thresh_r;
		if (wr_thresh) begin
			thresh_nxt = I_CB_REQ.wdata;
			count_nxt  = I_CB_REQ.wdata;
		end
	end

	// reset empties the counter; the threshold starts at zero as well
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			thresh_r <= lem_udr_pkg::RST_THRESH;
			count_r  <= lem_udr_pkg::RST_COUNT;
		end else begin
			thresh_r <= thresh_nxt;
			count_r  <= count_nxt;
		end
	end

	// user sense/enable register
	logic [7:0] user_r;
	logic [7:0] user_nxt;
	logic [7:0] sense_set;

	// a write may clear sense bits but never set them, so software cannot
	// fake an outside event; hardware sets win over a same-cycle clear
	always_comb begin
		user_nxt  = user_r;
		sense_set = 8'h00;
		if (wr_user)
			user_nxt = (I_CB_REQ.wdata & ~lem_udr_pkg::USER_SENSE_MASK)
				| (I_CB_REQ.wdata & user_r & lem_udr_pkg::USER_SENSE_MASK);
		sense_set[lem_udr_pkg::USER_SENSE0_BIT] = sense_hit_r[0];
		sense_set[lem_udr_pkg::USER_SENSE1_BIT] = sense_hit_r[1];
		sense_set[lem_udr_pkg::USER_SENSE2_BIT] = sense_hit_r[2];
		user_nxt = user_nxt | sense_set;
	end

	// reserved bits start at zero and are only ever stored
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B)
			user_r <= lem_udr_pkg::RST_USER;
		else
			user_r <= user_nxt;
	end

	// condition flags owned by this slice and their compare copy
	logic [7:0] icr_r;
	logic [7:0] icr_nxt;
	logic [7:0] icr_cmp_r;
	logic [7:0] icr_cmp_nxt;
	logic [7:0] icr_set;
	logic [7:0] icr_diff;

	// a flag that differs from its compare copy, loaded when the host reads the flags, keeps its
	// value on a clear; one cleared and set again since that read matches the copy and is cleared
	always_comb begin
		icr_nxt     = icr_r;
		icr_cmp_nxt = icr_cmp_r;
		icr_set     = 8'h00;
		icr_diff    = (icr_r ^ icr_cmp_r) & lem_udr_pkg::ICR_IMPL_MASK;
		if (thresh_hit)
			icr_set[lem_udr_pkg::ICR_LINK_THRESH_BIT] = 1'b1;
		if (wr_count)
			icr_set[lem_udr_pkg::ICR_WRITE_REJECT_BIT] = 1'b1;
		if (wr_icr) begin
			icr_nxt = ((I_CB_REQ.wdata & ~icr_diff) | (icr_r & icr_diff))
				& lem_udr_pkg::ICR_IMPL_MASK;
			if (icr_diff != 8'h00)
				icr_set[lem_udr_pkg::ICR_COND_INHIBIT_BIT] = 1'b1;
		end
		if (wr_icr_cmp)
			icr_cmp_nxt = I_CB_REQ.wdata & lem_udr_pkg::ICR_IMPL_MASK;
		if (rd_icr)
			icr_cmp_nxt = icr_r;
		// hardware sets win over a host clear in the same cycle
		icr_nxt = icr_nxt | icr_set;
	end

	// flags and the compare copy start clear
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			icr_r     <= lem_udr_pkg::RST_ICR;
			icr_cmp_r <= lem_udr_pkg::RST_ICR_CMP;
		end else begin
			icr_r     <= icr_nxt;
			icr_cmp_r <= icr_cmp_nxt;
		end
	end

	// bus answer: ack and data stand for the one cycle after the taking edge
	lem_udr_pkg::cb_rsp_t rsp_nxt;

	always_comb begin
		rsp_nxt.ack   = I_CB_REQ.sel;
		rsp_nxt.rdata = 8'h00;
		if (rd_en) begin
			case (I_CB_REQ.addr)
				lem_udr_pkg::ADDR_THRESH:  rsp_nxt.rdata = thresh_r;
				lem_udr_pkg::ADDR_COUNT:   rsp_nxt.rdata = count_r;
				lem_udr_pkg::ADDR_USER:    rsp_nxt.rdata = user_r;
				lem_udr_pkg::ADDR_ICR:     rsp_nxt.rdata = icr_r;
				lem_udr_pkg::ADDR_ICR_CMP: rsp_nxt.rdata = icr_cmp_r;
				default:                   rsp_nxt.rdata = 8'h00;
			endcase
		end
	end

	// registered so the host sees a clean answer, at the cost of one cycle
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B)
			O_CB_RSP <= '0;
		else
			O_CB_RSP <= rsp_nxt;
	end

	// enable pins and the condition register copy
	logic [2:0] enable_nxt;

	always_comb begin
		enable_nxt[0] = user_r[lem_udr_pkg::USER_ENABLE0_BIT];
		enable_nxt[1] = user_r[lem_udr_pkg::USER_ENABLE1_BIT];
		// single-path parts hold the third pin low whatever the bit says
		enable_nxt[2] = user_r[lem_udr_pkg::USER_ENABLE2_BIT] & DUAL_PATH;
	end

	// pins leave straight from flops so outside logic sees no glitches
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_ENABLE_PIN <= 3'h0;
			O_ICR        <= lem_udr_pkg::RST_ICR;
		end else begin
			O_ENABLE_PIN <= enable_nxt;
			O_ICR        <= icr_nxt;
		end
	end

endmodule

/* File: include/lem_udr_pkg.sv */
// constants, register map and bus carrier types for the link error monitor
// and user sense/enable register; shared by the design and the bench
package lem_udr_pkg;

	// control bus register offsets (6-bit address space)
	localparam logic [5:0] ADDR_ICR      = 6'h02;
	localparam logic [5:0] ADDR_THRESH   = 6'h15;
	localparam logic [5:0] ADDR_COUNT    = 6'h16;
	localparam logic [5:0] ADDR_USER     = 6'h17;
	localparam logic [5:0] ADDR_ICR_CMP  = 6'h1A;

	// interrupt condition register flag positions
	localparam int ICR_WRITE_REJECT_BIT  = 2;
	localparam int ICR_COND_INHIBIT_BIT  = 3;
	localparam int ICR_LINK_THRESH_BIT   = 4;
	// flags this slice implements; the rest read as zero
	localparam logic [7:0] ICR_IMPL_MASK = 8'h1C;

	// user register field positions
	localparam int USER_SENSE0_BIT  = 0;
	localparam int USER_SENSE1_BIT  = 1;
	localparam int USER_ENABLE0_BIT = 2;
	localparam int USER_ENABLE1_BIT = 3;
	localparam int USER_SENSE2_BIT  = 4;
	localparam int USER_ENABLE2_BIT = 6;
	localparam logic [7:0] USER_SENSE_MASK = 8'h13;

	// reset values
	localparam logic [7:0] RST_THRESH  = 8'h00;
	localparam logic [7:0] RST_COUNT   = 8'h00;
	localparam logic [7:0] RST_USER    = 8'h00;
	localparam logic [7:0] RST_ICR     = 8'h00;
	localparam logic [7:0] RST_ICR_CMP = 8'h00;

	// sense pin qualification time and its cycle count at 20 MHz
	localparam int SENSE_HOLD_NS   = 200;
	localparam int CLK_PERIOD_NS   = 50;
	localparam int SENSE_HOLD_CYC  = (SENSE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SENSE_HOLD_CNT = 4'(SENSE_HOLD_CYC);

	// one control bus access, presented for a single cycle
	typedef struct packed {
		logic       sel;
		logic       wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} cb_req_t;

	// answer to an access
	typedef struct packed {
		logic       ack;
		logic [7:0] rdata;
	} cb_rsp_t;

endpackage

/* File: dv/lem_udr_properties.sv */
// port checks for the link error monitor and user register block
// bound onto lem_udr; sees only its ports
`timescale 1ns/1ps
module lem_udr_properties #(
	parameter bit DUAL_PATH = 1'b1
) (
	input wire logic                 I_CLK,
	input wire logic                 I_RST_B,
	input wire lem_udr_pkg::cb_req_t I_CB_REQ,
	input wire logic                 I_LINK_ERR,
	input wire logic [2:0]           I_SENSE_PIN,
	input wire lem_udr_pkg::cb_rsp_t O_CB_RSP,
	input wire logic [2:0]           O_ENABLE_PIN,
	input wire logic [7:0]           O_ICR
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	// write strobe to one address, the first step of two checks
	sequence s_wr(a);
		I_CB_REQ.sel && I_CB_REQ.wr && I_CB_REQ.addr == a;
	endsequence
	property p_ack; I_CB_REQ.sel |=> O_CB_RSP.ack; endproperty
	property p_no_ack; !I_CB_REQ.sel |=> !O_CB_RSP.ack; endproperty
	property p_wr_rdata; I_CB_REQ.sel && I_CB_REQ.wr |=> O_CB_RSP.rdata == 8'h00; endproperty
	property p_unmapped; I_CB_REQ.sel && I_CB_REQ.addr == 6'h3F |=> O_CB_RSP.rdata == 8'h00;
	endproperty
	property p_reject; s_wr(lem_udr_pkg::ADDR_COUNT) |=> O_ICR[2]; endproperty
	// a threshold flag may only come from an error or a host write
	property p_thr_flag; $rose(O_ICR[4]) |-> $past(I_LINK_ERR) || $past(I_CB_REQ.wr); endproperty
	property p_reject_hold; $fell(O_ICR[2]) |-> $past(I_CB_REQ.sel && I_CB_REQ.wr); endproperty
	property p_enable; s_wr(lem_udr_pkg::ADDR_USER) |=> ##1 O_ENABLE_PIN ==
		{DUAL_PATH && $past(I_CB_REQ.wdata[6], 2), $past(I_CB_REQ.wdata[3:2], 2)};
	endproperty
	property p_icr_impl; (O_ICR & ~lem_udr_pkg::ICR_IMPL_MASK) == 8'h00; endproperty
	a_ack: assert property (p_ack) else $error("no ack after access");
	a_no_ack: assert property (p_no_ack) else $error("ack without access");
	a_wr_rdata: assert property (p_wr_rdata) else $error("write returned data");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_reject: assert property (p_reject) else $error("count write not rejected");
	a_thr_flag: assert property (p_thr_flag) else $error("threshold flag without cause");
	a_reject_hold: assert property (p_reject_hold) else $error("reject flag lost");
	a_enable: assert property (p_enable) else $error("enable pins wrong");
	a_icr_impl: assert property (p_icr_impl) else $error("unused flag set");
endmodule

bind lem_udr lem_udr_properties #(.DUAL_PATH(DUAL_PATH)) u_props (.I_CLK(I_CLK),
	.I_RST_B(I_RST_B), .I_CB_REQ(I_CB_REQ), .I_LINK_ERR(I_LINK_ERR),
	.I_SENSE_PIN(I_SENSE_PIN), .O_CB_RSP(O_CB_RSP), .O_ENABLE_PIN(O_ENABLE_PIN), .O_ICR(O_ICR));

/* File: dv/cb_host.sv */
// management host model: one control bus access at a time
// assumes ack comes in the cycle after the taking edge
`timescale 1ns/1ps
module cb_host (
	input  wire logic                 i_clk,
	input  wire lem_udr_pkg::cb_rsp_t i_rsp,
	output lem_udr_pkg::cb_req_t      o_req
);
	initial o_req = '0;
	// strobe is a one-cycle pulse, so it drops before the answer is read
	task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] wd,
		output logic [7:0] rd, output logic ok);
		@(negedge i_clk);
		o_req = '{1'b1, wr, a, wd};
		@(negedge i_clk);
		o_req = '0;
		ok = (i_rsp.ack === 1'b1);
		rd = i_rsp.rdata;
	endtask
endmodule

/* File: dv/tb_lem_udr.sv */
// self-checking bench for lem_udr through the host model
// assumes the 4-cycle sense qualification of the package
`timescale 1ns/1ps
module tb_lem_udr;
	logic                 clk = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 link_err = 1'b0;
	logic [2:0]           sense = 3'h0;
	lem_udr_pkg::cb_req_t req;
	lem_udr_pkg::cb_rsp_t rsp;
	logic [2:0]           en_pin;
	logic [7:0]           interrupt_condition_register;
	logic [7:0]           rd;
	logic                 ok;
	int                   fail_count = 0;
	int                   tests_run = 0;
	always #25 clk = ~clk;
	lem_udr #(.DUAL_PATH(1'b1)) uut (.I_CLK(clk), .I_RST_B(rst_b), .I_CB_REQ(req),
		.I_LINK_ERR(link_err), .I_SENSE_PIN(sense), .O_CB_RSP(rsp),
		.O_ENABLE_PIN(en_pin), .O_ICR(interrupt_condition_register));
	cb_host host (.i_clk(clk), .i_rsp(rsp), .o_req(req));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d);
		host.access(wr, a, d, rd, ok);
		check({7'h00, ok}, 8'h01);
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		check(rd, exp);
	endtask
	task automatic pulse_err(input int n);
		repeat (n) begin
			@(negedge clk) link_err = 1'b1;
			@(negedge clk) link_err = 1'b0;
		end
	endtask
	task automatic t_counter();
		xfer(1'b1, lem_udr_pkg::ADDR_THRESH, 8'h03);
		rdchk(lem_udr_pkg::ADDR_THRESH, 8'h03);
		rdchk(lem_udr_pkg::ADDR_COUNT, 8'h03);
		pulse_err(2);
		rdchk(lem_udr_pkg::ADDR_COUNT, 8'h01);
		check(interrupt_condition_register & 8'h10, 8'h00);
		pulse_err(1);
		rdchk(lem_udr_pkg::ADDR_COUNT, 8'h03);
		check(interrupt_condition_register & 8'h10, 8'h10);
		xfer(1'b1, lem_udr_pkg::ADDR_COUNT, 8'h5A);
		rdchk(lem_udr_pkg::ADDR_COUNT, 8'h03);
		check(interrupt_condition_register & 8'h04, 8'h04);
	endtask
	// compare copy is 14h; the second clear finds bit 4 stale, still clears bit 2 and sets the inhibit flag
	task automatic t_icr();
		rdchk(lem_udr_pkg::ADDR_ICR, 8'h14);
		rdchk(lem_udr_pkg::ADDR_ICR_CMP, 8'h14);
		xfer(1'b1, lem_udr_pkg::ADDR_ICR, 8'h00);
		xfer(1'b1, lem_udr_pkg::ADDR_COUNT, 8'h00);
		check(interrupt_condition_register, 8'h04);
		xfer(1'b1, lem_udr_pkg::ADDR_ICR, 8'h00);
		@(negedge clk);
		check(interrupt_condition_register, 8'h08);
	endtask
	task automatic t_user();
		xfer(1'b1, lem_udr_pkg::ADDR_USER, 8'hFF);
		@(negedge clk);
		check({5'h00, en_pin}, 8'h07);
		rdchk(lem_udr_pkg::ADDR_USER, 8'hEC);
		sense = 3'h7;
		repeat (3) @(negedge clk);
		sense = 3'h0;
		repeat (4) @(negedge clk);
		rdchk(lem_udr_pkg::ADDR_USER, 8'hEC);
		sense = 3'h7;
		repeat (10) @(negedge clk);
		sense = 3'h0;
		repeat (4) @(negedge clk);
		rdchk(lem_udr_pkg::ADDR_USER, 8'hFF);
		rdchk(lem_udr_pkg::ADDR_USER, 8'hFF);
		xfer(1'b1, lem_udr_pkg::ADDR_USER, 8'h00);
		rdchk(lem_udr_pkg::ADDR_USER, 8'h00);
		check({5'h00, en_pin}, 8'h00);
	endtask
	// a reset in mid-run must empty the counter, threshold, user and flag registers again
	task automatic t_reset();
		xfer(1'b1, lem_udr_pkg::ADDR_THRESH, 8'h05);
		xfer(1'b1, lem_udr_pkg::ADDR_USER, 8'h4C);
		@(negedge clk) rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		check({5'h00, en_pin}, 8'h00);
		check(interrupt_condition_register, lem_udr_pkg::RST_ICR);
		rdchk(lem_udr_pkg::ADDR_COUNT, lem_udr_pkg::RST_COUNT);
		rdchk(lem_udr_pkg::ADDR_THRESH, lem_udr_pkg::RST_THRESH);
		rdchk(lem_udr_pkg::ADDR_USER, lem_udr_pkg::RST_USER);
	endtask
	task automatic end_sim();
		if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// cuts a hang short
	initial begin
		#1000000;
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		rdchk(lem_udr_pkg::ADDR_COUNT, lem_udr_pkg::RST_COUNT);
		rdchk(lem_udr_pkg::ADDR_USER, lem_udr_pkg::RST_USER);
		rdchk(6'h3F, 8'h00);
		t_counter();
		t_icr();
		t_user();
		t_reset();
		end_sim();
	end
endmodule
